// file: include/seq_pkg.sv
// Purpose: Shared constants and types of the pattern sequencer.
// Assumes: One vector word holds drive, use, compare, opcode and operand.
// Notes:   Field positions are derived, so the pin count sets all but the drive field at bit 0.
package seq_pkg;
    // Vector word layout
    localparam int PIN_W   = 8;
    localparam int CNT_W   = 8;
    localparam int OP_W    = 2;
    localparam int DRV_LSB = 0;
    localparam int USE_LSB = DRV_LSB + PIN_W;
    localparam int CMP_BIT = USE_LSB + PIN_W;
    localparam int OP_LSB  = CMP_BIT + 1;
    localparam int CNT_LSB = OP_LSB + OP_W;
    localparam int WORD_W  = CNT_LSB + CNT_W;
    // Sizes of the sequencer
    localparam int ADDR_W_DEF = 10;
    localparam int ADDR_W_MIN = 2;
    localparam int ADDR_W_MAX = 16;
    localparam int PER_W      = 8;
    localparam int FAIL_W     = 16;

    // Vector opcodes: next, end of burst, hold loop, scan
    typedef enum logic [OP_W-1:0] {
        OP_NEXT,
        OP_HALT,
        OP_HOLD,
        OP_SCAN
    } opcode_t;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [PIN_W-1:0]  pins_t;
endpackage

// file: include/vec_mem_if.sv
// Purpose: Carrier between sequencer and its vector memory.
// Assumes: One write port and one registered read port.
// Notes:   Read data follow the read address by one clock.
`timescale 1ns/1ps
interface vec_mem_if #(
    parameter int AW = seq_pkg::ADDR_W_DEF
) (
    input wire logic clk
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [AW-1:0] raddr;
    seq_pkg::word_t wdata;
    seq_pkg::word_t rdata;

    modport mem  (input clk, we, waddr, wdata, raddr, output rdata);
    modport user (output we, waddr, wdata, raddr, input rdata);
endinterface

// file: logic/pattern_sequencer.sv
// Purpose: Vector sequencer with keep-alive looping and scan vectors.
// Assumes: Patterns are written into vector memory before a burst.
// Notes:   One vector per time set period; abort acts at a vector edge.
// Behaviour
// RL1 - Keep-alive keeps looping while loading, reconfiguring or time sets change.
// RL2 - Hold-loop opcode in a standard pattern jumps into the keep-alive pattern.
// RL3 - Hold-loop on last keep-alive vector restarts it until burst or abort.
// RL4 - Controller loads keep-alive before bursting a pattern that jumps there.
// RL5 - Only one keep-alive slot; load and unload act on it.
// RL6 - Failure results of the jumping standard pattern freeze during keep-alive.
// RL7 - Pins unused by keep-alive keep their last driven state.
// RL8 - Scan opcode makes a scan vector; operand gives its scan cycle count.
// RL9 - The scan template row is never applied as a cycle itself.
// RL10 - Parallel pins repeat template states unchanged on every scan cycle.
// RL11 - Scan pins take their own per-cycle state on every scan cycle.
// RL12 - Abort stops at a vector boundary and returns the sequencer to idle.
`timescale 1ns/1ps
module pattern_sequencer #(
    parameter int ADDR_W = seq_pkg::ADDR_W_DEF
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_load_we,
    input  wire logic [ADDR_W-1:0]          i_load_addr,
    input  wire seq_pkg::word_t             i_load_data,
    input  wire logic                       i_ka_load,
    input  wire logic [ADDR_W-1:0]          i_ka_base,
    input  wire logic [ADDR_W-1:0]          i_ka_end,
    input  wire logic                       i_ka_unload,
    input  wire logic                       i_burst,
    input  wire logic [ADDR_W-1:0]          i_burst_addr,
    input  wire logic [seq_pkg::PER_W-1:0]  i_period,
    input  wire seq_pkg::pins_t             i_scan_pins,
    input  wire logic                       i_abort,
    input  wire seq_pkg::pins_t             i_pin_in,
    output seq_pkg::pins_t                  o_pin_drive,
    output seq_pkg::pins_t                  o_pin_oe_n,
    output logic                            o_busy,
    output logic                            o_ka_active,
    output logic                            o_ka_loaded,
    output logic                            o_no_ka_err,
    output logic      [seq_pkg::FAIL_W-1:0] o_fail_count
);
    import seq_pkg::*;

    if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX) begin : g_bad_addr
        $error("pattern_sequencer: ADDR_W out of range");
    end

    typedef enum logic [1:0] {
        S_IDLE,
        S_FETCH,
        S_APPLY
    } state_t;

    typedef struct packed {
        state_t              state;
        logic                busy;
        logic                ka_mode;
        logic                ka_valid;
        logic [ADDR_W-1:0]   ka_base;
        logic [ADDR_W-1:0]   ka_end;
        logic [ADDR_W-1:0]   addr;
        logic [ADDR_W-1:0]   burst_addr;
        logic                burst_pend;
        logic                abort_pend;
        pins_t               tmpl_drv;
        pins_t               tmpl_use;
        pins_t               scan_mask;
        pins_t               drive;
        pins_t               oe_n;
        logic [CNT_W-1:0]    scan_left;
        logic [PER_W-1:0]    period;
        logic [PER_W-1:0]    div_cnt;
        logic                tick;
        logic [FAIL_W-1:0]   fail_cnt;
        logic                no_ka;
    } seq_t;

    seq_t st_reg;
    seq_t st_next;

    vec_mem_if #(.AW(ADDR_W)) mbus (.clk(i_ref_clk));

    vec_mem #(.AW(ADDR_W)) u_mem (
        .m (mbus)
    );

    // Bit merge: masked bits take the new value
    function automatic pins_t merge(pins_t old_v, pins_t new_v, pins_t msk);
        return (old_v & ~msk) | (new_v & msk);
    endfunction

    // Fresh burst; keep-alive slot is left untouched
    function automatic seq_t start_burst(seq_t s, logic [ADDR_W-1:0] a,
                                         logic [PER_W-1:0] per,
                                         pins_t scan_pins);
        seq_t r;
        r            = s;
        r.state      = S_FETCH;
        r.busy       = 1'b1;
        r.ka_mode    = 1'b0;
        r.addr       = a;
        r.burst_pend = 1'b0;
        r.abort_pend = 1'b0;
        r.scan_left  = '0;
        r.period     = per;
        r.div_cnt    = per;
        r.scan_mask  = scan_pins;
        r.fail_cnt   = '0;
        r.no_ka      = 1'b0;
        return r;
    endfunction

    // Fields of the vector word in view
    opcode_t          w_op;
    pins_t            w_drv;
    pins_t            w_use;
    logic             w_cmp;
    logic [CNT_W-1:0] w_cnt;
    logic             w_fail;
    logic             in_ka_region;
    assign w_op   = opcode_t'(mbus.rdata[OP_LSB +: OP_W]);
    assign w_drv  = mbus.rdata[DRV_LSB +: PIN_W];
    assign w_use  = mbus.rdata[USE_LSB +: PIN_W];
    assign w_cmp  = mbus.rdata[CMP_BIT];
    assign w_cnt  = mbus.rdata[CNT_LSB +: CNT_W];
    assign w_fail = w_cmp && (((i_pin_in ^ w_drv) & w_use) != '0);

    // Loads may go on, but never overwrite a held keep-alive pattern
    assign in_ka_region = st_reg.ka_valid && i_load_addr >= st_reg.ka_base
                          && i_load_addr <= st_reg.ka_end;
    assign mbus.we    = i_load_we && !in_ka_region; // RL1
    assign mbus.waddr = i_load_addr;
    assign mbus.wdata = i_load_data;
    assign mbus.raddr = st_reg.addr;

    // Next state of the whole sequencer
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        // Vector period divider, period latched per burst
        if (st_reg.busy) begin
            if (st_reg.div_cnt == '0) begin
                st_next.div_cnt = st_reg.period; // RL1
                st_next.tick    = 1'b1;
            end else begin
                st_next.div_cnt = st_reg.div_cnt - 1'b1;
            end
        end
        // Single keep-alive slot, frozen while it runs
        if (!st_reg.ka_mode) begin
            if (i_ka_load) begin
                st_next.ka_valid = 1'b1; // RL5
                st_next.ka_base  = i_ka_base;
                st_next.ka_end   = i_ka_end;
            end else if (i_ka_unload) begin
                st_next.ka_valid = 1'b0; // RL5
            end
        end
        if (i_abort && st_reg.busy) begin
            st_next.abort_pend = 1'b1;
        end
        if (i_burst && st_reg.ka_mode) begin
            st_next.burst_pend = 1'b1;
            st_next.burst_addr = i_burst_addr;
        end
        case (st_reg.state)
            S_IDLE: begin
                if (i_burst) begin
                    st_next = start_burst(st_next, i_burst_addr, i_period,
                                          i_scan_pins);
                end
            end
            S_FETCH: begin
                st_next.state = S_APPLY;
            end
            S_APPLY: begin
                if (st_reg.scan_left == '0 && w_op == OP_SCAN
                    && !(st_reg.tick && st_reg.abort_pend)) begin
                    // Template only latched, no cycle spent; abort wins
                    st_next.tmpl_drv  = w_drv; // RL9
                    st_next.tmpl_use  = w_use;
                    st_next.scan_left = w_cnt; // RL8
                    st_next.addr      = st_reg.addr + 1'b1;
                    st_next.state     = S_FETCH;
                end else if (st_reg.tick) begin
                    if (st_reg.abort_pend) begin
                        st_next.state      = S_IDLE; // RL12
                        st_next.busy       = 1'b0;
                        st_next.ka_mode    = 1'b0;
                        st_next.abort_pend = 1'b0;
                        st_next.burst_pend = 1'b0;
                        st_next.scan_left  = '0;
                    end else if (st_reg.ka_mode && st_reg.burst_pend) begin
                        st_next = start_burst(st_next, st_reg.burst_addr,
                                              i_period, i_scan_pins); // RL3
                    end else if (st_reg.scan_left != '0) begin
                        // Parallel from template, scan pins from the row
                        st_next.drive = merge(st_reg.drive,
                            merge(st_reg.tmpl_drv, w_drv, st_reg.scan_mask),
                            st_reg.tmpl_use); // RL10 RL11
                        st_next.oe_n  = merge(st_reg.oe_n, '0,
                                              st_reg.tmpl_use);
                        st_next.scan_left = st_reg.scan_left - 1'b1;
                        st_next.addr      = st_reg.addr + 1'b1;
                        st_next.state     = S_FETCH;
                    end else begin
                        // Unused pins keep their last state
                        st_next.drive = merge(st_reg.drive, w_drv, w_use); // RL7
                        st_next.oe_n  = merge(st_reg.oe_n, '0, w_use);
                        if (w_fail && !st_reg.ka_mode
                            && st_reg.fail_cnt != '1) begin
                            st_next.fail_cnt = st_reg.fail_cnt + 1'b1; // RL6
                        end
                        st_next.addr  = st_reg.addr + 1'b1;
                        st_next.state = S_FETCH;
                        if (w_op == OP_HALT) begin
                            st_next.state = S_IDLE;
                            st_next.busy  = 1'b0;
                        end else if (w_op == OP_HOLD) begin
                            if (st_reg.ka_mode || st_reg.ka_valid) begin
                                st_next.ka_mode = 1'b1; // RL2
                                st_next.addr    = st_reg.ka_base; // RL3
                            end else begin
                                // Nothing loaded to jump into
                                st_next.no_ka = 1'b1; // RL4
                                st_next.state = S_IDLE;
                                st_next.busy  = 1'b0;
                            end
                        end
                    end
                end
            end
            default: begin
                st_next.state = S_IDLE;
            end
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st_reg      <= '0;
            st_reg.oe_n <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign o_pin_drive  = st_reg.drive;
    assign o_pin_oe_n   = st_reg.oe_n;
    assign o_busy       = st_reg.busy;
    assign o_ka_active  = st_reg.ka_mode;
    assign o_ka_loaded  = st_reg.ka_valid;
    assign o_no_ka_err  = st_reg.no_ka;
    assign o_fail_count = st_reg.fail_cnt;

    // Assertion helpers
    logic apply_tick;
    logic is_tmpl;
    logic scan_row;
    logic vec_apply;
    assign apply_tick = st_reg.state == S_APPLY && st_reg.tick
                        && !st_reg.abort_pend
                        && !(st_reg.ka_mode && st_reg.burst_pend);
    assign is_tmpl    = st_reg.state == S_APPLY && st_reg.scan_left == '0
                        && w_op == OP_SCAN
                        && !(st_reg.tick && st_reg.abort_pend);
    assign scan_row   = apply_tick && st_reg.scan_left != '0;
    assign vec_apply  = apply_tick && st_reg.scan_left == '0
                        && w_op != OP_SCAN;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    property p_ka_keeps;
        st_reg.ka_mode && !st_reg.abort_pend && !i_abort
        && !st_reg.burst_pend && !i_burst
        && !(vec_apply && w_op == OP_HALT) |=> st_reg.ka_mode;
    endproperty
    a_ka_keeps: assert property (p_ka_keeps) // RL1
        else $error("keep-alive stopped without abort or burst");
    property p_enter_ka;
        vec_apply && w_op == OP_HOLD && !st_reg.ka_mode && st_reg.ka_valid
        |=> st_reg.ka_mode && st_reg.addr == $past(st_reg.ka_base)
        ##1 st_reg.state == S_APPLY;
    endproperty
    a_enter_ka: assert property (p_enter_ka) // RL2
        else $error("hold opcode did not enter keep-alive");
    property p_loop_ka;
        vec_apply && w_op == OP_HOLD && st_reg.ka_mode
        |=> st_reg.ka_mode && st_reg.addr == st_reg.ka_base;
    endproperty
    a_loop_ka: assert property (p_loop_ka) // RL3
        else $error("keep-alive did not restart");
    property p_one_slot;
        st_reg.ka_mode && (i_ka_load || i_ka_unload)
        |=> $stable(st_reg.ka_base) && st_reg.ka_valid;
    endproperty
    a_one_slot: assert property (p_one_slot) // RL5
        else $error("keep-alive slot changed while running");
    property p_freeze;
        $past(st_reg.ka_mode) && st_reg.ka_mode |-> $stable(st_reg.fail_cnt);
    endproperty
    a_freeze: assert property (p_freeze) // RL6
        else $error("failure count changed during keep-alive");
    property p_hold_unused;
        vec_apply
        |=> ((st_reg.drive ^ $past(st_reg.drive)) & ~$past(w_use)) == '0;
    endproperty
    a_hold_unused: assert property (p_hold_unused) // RL7
        else $error("unused pin changed state");
    property p_scan_count;
        is_tmpl |=> st_reg.scan_left == $past(w_cnt);
    endproperty
    a_scan_count: assert property (p_scan_count) // RL8
        else $error("scan count not taken from operand");
    property p_tmpl_idle;
        is_tmpl |=> $stable(st_reg.drive) && $stable(st_reg.oe_n);
    endproperty
    a_tmpl_idle: assert property (p_tmpl_idle) // RL9
        else $error("template row applied as a cycle");
    property p_par_repeat;
        scan_row |=> ((st_reg.drive ^ $past(st_reg.tmpl_drv))
                      & $past(st_reg.tmpl_use & ~st_reg.scan_mask)) == '0;
    endproperty
    a_par_repeat: assert property (p_par_repeat) // RL10
        else $error("parallel pin differs from template");
    property p_scan_pin;
        scan_row |=> ((st_reg.drive ^ $past(w_drv))
                      & $past(st_reg.tmpl_use & st_reg.scan_mask)) == '0;
    endproperty
    a_scan_pin: assert property (p_scan_pin) // RL11
        else $error("scan pin missed its cycle state");
    property p_abort;
        st_reg.state == S_APPLY && st_reg.tick && st_reg.abort_pend
        |=> st_reg.state == S_IDLE && !st_reg.ka_mode && !st_reg.busy;
    endproperty
    a_abort: assert property (p_abort) // RL12
        else $error("abort did not return to idle");

    c_enter_ka: cover property (vec_apply && w_op == OP_HOLD
                                && !st_reg.ka_mode && st_reg.ka_valid);
    c_scan_row: cover property (scan_row);
    c_ka_abort: cover property (st_reg.ka_mode && st_reg.abort_pend
                                && st_reg.tick && st_reg.state == S_APPLY);
    c_ka_burst: cover property (st_reg.ka_mode && st_reg.burst_pend
                                && st_reg.tick && st_reg.state == S_APPLY);
endmodule // pattern_sequencer

// file: logic/vec_mem.sv
// Purpose: Vector memory holding standard and keep-alive patterns.
// Assumes: Synchronous write, registered read.
// Notes:   A write to the address being read shows one clock later.
`timescale 1ns/1ps
module vec_mem #(
    parameter int AW = seq_pkg::ADDR_W_DEF
) (
    vec_mem_if.mem m
);
    import seq_pkg::*;

    word_t mem_reg [2**AW];

    // Write port and registered read port
    always_ff @(posedge m.clk) begin
        if (m.we) begin
            mem_reg[m.waddr] <= m.wdata;
        end
        m.rdata <= mem_reg[m.raddr];
    end
endmodule // vec_mem

// file: testbench/dut_model.sv
// Purpose: Behavioural device under test facing the sequencer pins.
// Assumes: The device answers with a static response level set by bench.
// Notes:   Pin 0 feeds the device PLL reference; rising edges are counted.
`timescale 1ns/1ps
module dut_model (
    input  wire logic           i_ref_clk,
    input  wire seq_pkg::pins_t i_drive,
    input  wire seq_pkg::pins_t i_oe_n,
    input  wire seq_pkg::pins_t i_resp,
    output seq_pkg::pins_t      o_pin_in,
    output int                  o_ref_edges
);
    import seq_pkg::*;
    int   edge_cnt = 0;
    logic ref_last_reg;
    // Device outputs its response level on every pin
    assign o_pin_in    = i_resp;
    assign o_ref_edges = edge_cnt;
    // Count PLL reference edges while pin 0 is driven
    always @(posedge i_ref_clk) begin
        if (!i_oe_n[0] && i_drive[0] && !ref_last_reg)
            edge_cnt <= edge_cnt + 1;
        ref_last_reg <= i_drive[0];
    end
endmodule // dut_model

// file: testbench/tb.sv
// Purpose: Self-checking bench of the pattern sequencer.
// Assumes: Time set of one gives a vector every two clocks.
// Notes:   Applied drive values are logged whenever they change.
`timescale 1ns/1ps
module tb;
    import seq_pkg::*;
    logic        clk, rstn, we, ka_load, ka_unload, burst, abort;
    logic [9:0]  addr, ka_base, ka_end, burst_addr;
    word_t       wdata;
    logic [7:0]  period;
    pins_t       scan_pins, pin_in, drive, oe_n, resp;
    logic        busy, ka_active, ka_loaded, no_ka_err;
    logic [15:0] fail_count;
    int          ref_edges, n_mismatch, total_checks, e0, k;
    pins_t       seen[$];
    pins_t       exp_q[$];

    pattern_sequencer u_dut (.i_ref_clk(clk), .i_rstn(rstn),
        .i_load_we(we), .i_load_addr(addr), .i_load_data(wdata),
        .i_ka_load(ka_load), .i_ka_base(ka_base), .i_ka_end(ka_end),
        .i_ka_unload(ka_unload), .i_burst(burst), .i_burst_addr(burst_addr),
        .i_period(period), .i_scan_pins(scan_pins), .i_abort(abort),
        .i_pin_in(pin_in), .o_pin_drive(drive), .o_pin_oe_n(oe_n),
        .o_busy(busy), .o_ka_active(ka_active), .o_ka_loaded(ka_loaded),
        .o_no_ka_err(no_ka_err), .o_fail_count(fail_count));
    dut_model u_model (.i_ref_clk(clk), .i_drive(drive), .i_oe_n(oe_n),
        .i_resp(resp), .o_pin_in(pin_in), .o_ref_edges(ref_edges));

    // Clock of 5 ns
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Log every change of the applied drive, right after its edge
    always @(drive) begin
        seen.push_back(drive);
    end

    task automatic chk_cnt(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_pins(string name, pins_t exp, pins_t got);
        chk_cnt(name, {8'h00, exp}, {8'h00, got});
    endtask
    task automatic chk_flag(string name, logic exp, logic got);
        chk_cnt(name, {15'h0000, exp}, {15'h0000, got});
    endtask
    function automatic word_t mk(pins_t d, pins_t u, logic c, opcode_t op,
                                 logic [7:0] n);
        return {n, op, c, u, d};
    endfunction
    task automatic wr(logic [9:0] a, word_t w);
        @(negedge clk);
        we = 1'b1; addr = a; wdata = w;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic wait_idle();
        for (k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk);
        chk_flag("busy", 1'b0, busy);
    endtask
    task automatic go(logic [9:0] a);
        burst_addr = a;
        pulse(burst);
    endtask
    task automatic wait_ka();
        for (k = 0; k < 100 && ka_active !== 1'b1; k++) @(negedge clk);
        chk_flag("ka_active", 1'b1, ka_active);
    endtask
    task automatic loops_on();
        e0 = ref_edges;
        repeat (40) @(negedge clk);
        chk_flag("ka toggling", 1'b1, ref_edges >= e0 + 8);
    endtask

    // Standard burst, a refused second burst and compare results
    task automatic t_standard();
        wr(10'h000, mk(8'h11, 8'hFF, 1'b0, OP_NEXT, 8'h00));
        wr(10'h001, mk(8'h2F, 8'h0F, 1'b0, OP_NEXT, 8'h00));
        wr(10'h002, mk(8'h33, 8'hFF, 1'b1, OP_HALT, 8'h00));
        resp = 8'h00;
        seen.delete();
        @(negedge clk);
        burst_addr = 10'h000; burst = 1'b1;
        @(negedge clk);
        burst_addr = 10'h014;
        @(negedge clk);
        burst = 1'b0;
        wait_idle();
        exp_q = '{8'h11, 8'h1F, 8'h33};
        chk_cnt("vectors", 16'h0003, 16'(seen.size()));
        foreach (exp_q[i]) chk_pins("drive", exp_q[i], seen[i]);
        chk_pins("oe_n", 8'h00, oe_n);
        chk_cnt("fail", 16'h0001, fail_count);
        resp = 8'h33;
        go(10'h000);
        wait_idle();
        chk_cnt("fail cleared", 16'h0000, fail_count);
    endtask

    // Keep-alive entry, looping, disturbance, abort and switch out
    task automatic t_keepalive();
        wr(10'h014, mk(8'hF0, 8'hFF, 1'b1, OP_NEXT, 8'h00));
        wr(10'h015, mk(8'hF0, 8'h00, 1'b0, OP_HOLD, 8'h00));
        wr(10'h028, mk(8'h01, 8'h01, 1'b1, OP_NEXT, 8'h00));
        wr(10'h029, mk(8'h00, 8'h01, 1'b1, OP_HOLD, 8'h00));
        resp = 8'h00;
        go(10'h014);
        wait_idle();
        chk_flag("no slot err", 1'b1, no_ka_err);
        ka_base = 10'h028; ka_end = 10'h029;
        pulse(ka_load);
        chk_flag("slot loaded", 1'b1, ka_loaded);
        go(10'h014);
        wait_ka();
        chk_flag("err cleared", 1'b0, no_ka_err);
        loops_on();
        chk_pins("held pins", 8'hF0, drive & 8'hFE);
        chk_pins("held oe", 8'h00, oe_n);
        wr(10'h028, mk(8'h00, 8'h01, 1'b0, OP_NEXT, 8'h00));
        wr(10'h005, mk(8'h77, 8'hFF, 1'b0, OP_HALT, 8'h00));
        period = 8'h07; ka_base = 10'h000; ka_end = 10'h003;
        pulse(ka_load);
        pulse(ka_unload);
        loops_on();
        chk_flag("slot kept", 1'b1, ka_loaded);
        chk_cnt("fail frozen", 16'h0001, fail_count);
        pulse(abort);
        wait_idle();
        chk_flag("ka ended", 1'b0, ka_active);
        period = 8'h01;
        go(10'h014);
        wait_ka();
        loops_on();
        go(10'h002);
        wait_idle();
        chk_pins("switched", 8'h33, drive);
        chk_flag("ka left", 1'b0, ka_active);
        pulse(ka_unload);
        chk_flag("slot empty", 1'b0, ka_loaded);
    endtask

    // Scan vector of three cycles with two scan pins
    task automatic t_scan();
        wr(10'h03C, mk(8'hA4, 8'hFF, 1'b0, OP_SCAN, 8'h03));
        for (int i = 1; i < 4; i++)
            wr(10'(60 + i), mk(8'h50 | 8'(i), 8'hFF, 1'b0, OP_NEXT, 8'h00));
        wr(10'h040, mk(8'h00, 8'hFF, 1'b0, OP_HALT, 8'h00));
        scan_pins = 8'h03;
        seen.delete();
        go(10'h03C);
        wait_idle();
        exp_q = '{8'hA5, 8'hA6, 8'hA7, 8'h00};
        chk_cnt("scan cycles", 16'h0004, 16'(seen.size()));
        chk_pins("no template", 8'hA5, seen[0]);
        foreach (exp_q[i]) chk_pins("scan row", exp_q[i], seen[i]);
        chk_pins("scan pins", 8'h02, seen[1] & 8'h03);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    // Main sequence
    initial begin
        rstn = 1'b0; we = 1'b0; ka_load = 1'b0; ka_unload = 1'b0;
        burst = 1'b0; abort = 1'b0; addr = '0; ka_base = '0; ka_end = '0;
        burst_addr = '0; wdata = '0; period = 8'h01; scan_pins = 8'h00;
        resp = 8'h00;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        chk_pins("oe reset", 8'hFF, oe_n);
        chk_pins("drive reset", 8'h00, drive);
        chk_flag("slot reset", 1'b0, ka_loaded);
        t_standard();
        t_keepalive();
        t_scan();
        summarize();
    end
endmodule // tb
